// ===== core/rxpq_core.v
`timescale 1ns/10ps
`include "rxpq_defines.vh"
// Operation
// - Frame-valid polarity bit inverts raw frame valid
// - Discard packets when pass false, if enabled
// - Line count change drops pass, needs threshold
// - Line size change drops pass, needs threshold
// - Parity mode 0: drop pass per error
// - Parity mode 1: hold pass off until threshold
// - Watchdog drops pass without frame end, two frames
// - Watchdog inactive when threshold is zero
// - Threshold zero: pass on receiver lock
// - Nonzero threshold: pass after that many frames
// - Masked rising sensor status edges latch
// - Masked falling sensor status edges latch
// - Per-port register copies chosen by port select
// - Read-only reference frequency in MHz
// - Line-valid polarity bit inverts raw line valid
// - Truncate frame on parity error when enabled
module rxpq_core
#(
  parameter NPORT    = 2,
  parameter DW       = 10,
  parameter FIFO_D   = 8,
  parameter WD_LIMIT = 24'd4000000
)
(
  input  wire              clk,
  input  wire              sys_rst,
  input  wire              ce,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  input  wire [NPORT-1:0]  rx_lock,
  input  wire [NPORT-1:0]  raw_fv,
  input  wire [NPORT-1:0]  raw_lv,
  input  wire [NPORT-1:0]  parity_err,
  input  wire [NPORT*8-1:0] remote_sensor_status,
  input  wire              ref_tick,
  input  wire [1:0]        pkt_port,
  input  wire [DW-1:0]     pkt_data,
  input  wire              pkt_valid,
  output reg               pkt_ready,
  output reg  [DW-1:0]     fwd_data,
  output reg               fwd_valid,
  input  wire              fwd_ready,
  output reg  [NPORT-1:0]  port_pass,
  output reg  [NPORT-1:0]  frame_truncate
);
  // ************************************************************
  // Register file
  // ************************************************************
  reg  [7:0]  port_sel;             // Port select, bit i opens port i
  reg  [7:0]  pol_cfg    [0:NPORT-1];  // Sync polarity config
  reg  [7:0]  pass_ctl   [0:NPORT-1];  // Pass qualify control
  reg  [7:0]  rise_mask  [0:NPORT-1];  // Rise interrupt mask
  reg  [7:0]  fall_mask  [0:NPORT-1];  // Fall interrupt mask
  reg  [7:0]  rise_sts   [0:NPORT-1];  // Latched rising edges
  reg  [7:0]  fall_sts   [0:NPORT-1];  // Latched falling edges
  reg  [7:0]  sts_prev   [0:NPORT-1];  // Previous sensor status
  reg  [NPORT-1:0] fv_d;            // Delayed frame valid (active high)
  reg  [NPORT-1:0] lv_d;            // Delayed line valid
  reg  [15:0] line_cnt   [0:NPORT-1];  // Lines this frame
  reg  [15:0] line_ref   [0:NPORT-1];  // Lines previous frame
  reg  [15:0] size_cnt   [0:NPORT-1];  // Words this line
  reg  [15:0] size_ref   [0:NPORT-1];  // Words previous line
  reg  [NPORT-1:0] ref_ok;          // Reference sizes captured
  reg  [1:0]  good_cnt   [0:NPORT-1];  // Valid frames counted
  reg  [NPORT-1:0] frame_bad;       // Error inside current frame
  reg  [NPORT-1:0] hold_off;        // Hold set by a fault that sets bad, cleared once threshold is met
  reg  [23:0] wd_cnt     [0:NPORT-1];  // Frame-end watchdog
  wire [7:0]  freq;                 // Reference frequency
  wire        f_in_ready;           // FIFO accepting
  wire [DW-1:0] f_data;             // FIFO output data
  wire        f_valid;              // FIFO output valid
  reg         f_push;               // Push into FIFO
  reg  [7:0]  rd_mux;               // Read data mux
  integer     i;                    // Port loop index
  integer     sel;                  // Lowest selected port

  // Active level of frame valid for a port
  function fv_act;
    input raw;
    input pol;
    begin
      fv_act = pol ? !raw : raw;
    end
  endfunction

  // Lowest selected port for reads
  always @*
  begin
    sel = 0;
    if (!port_sel[0] && port_sel[1])
      sel = 1;
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always @*
  begin
    rd_mux = 8'h00;
    case (reg_addr)
      `RXPQ_OFS_PORT_SEL:  rd_mux = port_sel;
      `RXPQ_OFS_POL_CFG:   rd_mux = pol_cfg[sel];
      `RXPQ_OFS_PASS_CTL:  rd_mux = pass_ctl[sel];
      `RXPQ_OFS_RISE_MASK: rd_mux = rise_mask[sel];
      `RXPQ_OFS_FALL_MASK: rd_mux = fall_mask[sel];
      `RXPQ_OFS_RISE_STS:  rd_mux = rise_sts[sel];
      `RXPQ_OFS_FALL_STS:  rd_mux = fall_sts[sel];
      `RXPQ_OFS_PASS_STS:  rd_mux = {7'h00, port_pass[sel]};
      `RXPQ_OFS_REF_FREQ:  rd_mux = freq;
      default:             rd_mux = 8'h00;
    endcase
  end

  // ************************************************************
  // Per-port qualification and registers
  // ************************************************************
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port_sel       <= `RXPQ_RST_PORT_SEL;
      reg_rdata      <= 8'h00;
      port_pass      <= {NPORT{1'b0}};
      frame_truncate <= {NPORT{1'b0}};
      fv_d           <= {NPORT{1'b0}};
      lv_d           <= {NPORT{1'b0}};
      ref_ok         <= {NPORT{1'b0}};
      frame_bad      <= {NPORT{1'b0}};
      hold_off       <= {NPORT{1'b0}};
      for (i = 0; i < NPORT; i = i + 1)
      begin
        pol_cfg[i]   <= `RXPQ_RST_POL_CFG;
        pass_ctl[i]  <= `RXPQ_RST_PASS_CTL;
        rise_mask[i] <= `RXPQ_RST_MASK;
        fall_mask[i] <= `RXPQ_RST_MASK;
        rise_sts[i]  <= 8'h00;
        fall_sts[i]  <= 8'h00;
        sts_prev[i]  <= 8'h00;
        line_cnt[i]  <= 16'h0000;
        line_ref[i]  <= 16'h0000;
        size_cnt[i]  <= 16'h0000;
        size_ref[i]  <= 16'h0000;
        good_cnt[i]  <= 2'b00;
        wd_cnt[i]    <= 24'h000000;
      end
    end
    else if (ce)
    begin
      if (reg_rd)
        reg_rdata <= rd_mux;
      if (reg_wr && reg_addr == `RXPQ_OFS_PORT_SEL)
        port_sel <= reg_wdata;
      for (i = 0; i < NPORT; i = i + 1)
      begin : port_loop
        reg fv;
        reg lv;
        reg fv_end;
        reg lv_end;
        reg bad;
        reg kill;
        reg [7:0] st;
        reg [1:0] th;
        fv     = fv_act(raw_fv[i], pol_cfg[i][`RXPQ_FV_POL_BIT]);
        lv     = fv_act(raw_lv[i], pol_cfg[i][`RXPQ_LV_POL_BIT]);
        fv_end = fv_d[i] && !fv;
        lv_end = lv_d[i] && !lv;
        st     = remote_sensor_status[i*8 +: 8];
        th     = pass_ctl[i][`RXPQ_THRESH_MSB:`RXPQ_THRESH_LSB];
        bad    = 1'b0;
        kill   = 1'b0;
        fv_d[i] <= fv;
        lv_d[i] <= lv;
        // Register writes reach every selected port copy
        if (reg_wr && port_sel[i])
        begin
          case (reg_addr)
            `RXPQ_OFS_POL_CFG:   pol_cfg[i]   <= reg_wdata;
            `RXPQ_OFS_PASS_CTL:  pass_ctl[i]  <= reg_wdata;
            `RXPQ_OFS_RISE_MASK: rise_mask[i] <= reg_wdata;
            `RXPQ_OFS_FALL_MASK: fall_mask[i] <= reg_wdata;
            default:             ;
          endcase
        end
        // Edge latches; new edge wins over clear-on-read
        if (reg_rd && i == sel && reg_addr == `RXPQ_OFS_RISE_STS)
          rise_sts[i] <= st & ~sts_prev[i] & rise_mask[i];
        else
          rise_sts[i] <= rise_sts[i] | (st & ~sts_prev[i] & rise_mask[i]);
        if (reg_rd && i == sel && reg_addr == `RXPQ_OFS_FALL_STS)
          fall_sts[i] <= ~st & sts_prev[i] & fall_mask[i];
        else
          fall_sts[i] <= fall_sts[i] | (~st & sts_prev[i] & fall_mask[i]);
        sts_prev[i] <= st;
        // Line size tracking
        if (lv)
          size_cnt[i] <= size_cnt[i] + 16'h0001;
        if (lv_end)
        begin
          size_cnt[i] <= 16'h0000;
          size_ref[i] <= size_cnt[i];
          line_cnt[i] <= line_cnt[i] + 16'h0001;
          if (ref_ok[i] && pass_ctl[i][`RXPQ_LINE_SIZE_BIT] && size_cnt[i] != size_ref[i])
            bad = 1'b1;
        end
        // Parity error handling
        frame_truncate[i] <= parity_err[i] && pol_cfg[i][`RXPQ_TRUNC_PAR_BIT] && fv;
        if (parity_err[i])
        begin
          kill = 1'b1;
          if (pass_ctl[i][`RXPQ_PAR_MODE_BIT])
            bad = 1'b1;
        end
        // Frame end: line count check and watchdog restart
        if (fv_end)
        begin
          line_cnt[i] <= 16'h0000;
          line_ref[i] <= line_cnt[i];
          ref_ok[i]   <= 1'b1;
          wd_cnt[i]   <= 24'h000000;
          if (ref_ok[i] && pass_ctl[i][`RXPQ_LINE_CNT_BIT] && line_cnt[i] != line_ref[i])
            bad = 1'b1;
        end
        else if (rx_lock[i] && wd_cnt[i] != WD_LIMIT)
          wd_cnt[i] <= wd_cnt[i] + 24'h000001;
        // Watchdog, ignored at threshold zero
        if (!pass_ctl[i][`RXPQ_WDOG_OFF_BIT] && th != 2'b00 && wd_cnt[i] == WD_LIMIT)
          bad = 1'b1;
        // Pass decision
        if (!rx_lock[i])
        begin
          port_pass[i] <= 1'b0;
          good_cnt[i]  <= 2'b00;
          hold_off[i]  <= 1'b0;
          frame_bad[i] <= 1'b0;
        end
        else if (th == 2'b00)
          port_pass[i] <= !kill;
        else if (bad)
        begin
          port_pass[i] <= 1'b0;
          good_cnt[i]  <= 2'b00;
          hold_off[i]  <= 1'b1;
          frame_bad[i] <= fv;  // Only a fault inside a frame spoils that frame
        end
        else
        begin
          if (fv_end)
          begin
            frame_bad[i] <= 1'b0;
            if (!frame_bad[i] && good_cnt[i] != 2'b11)
              good_cnt[i] <= good_cnt[i] + 2'b01;
          end
          if (!hold_off[i] && good_cnt[i] >= th)
            port_pass[i] <= !kill;
          else if (good_cnt[i] >= th)
          begin
            hold_off[i]  <= 1'b0;
            port_pass[i] <= !kill;
          end
          else
            port_pass[i] <= 1'b0;
          if (kill && fv)
            frame_bad[i] <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Packet path: discard while not passing
  // ************************************************************
  always @*
  begin
    f_push = 1'b0;
    if (pkt_valid && pkt_ready)
      f_push = !pass_ctl[pkt_port[0]][`RXPQ_DISCARD_EN_BIT] || port_pass[pkt_port[0]];
  end

  // Registered handshakes to the outside
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pkt_ready <= 1'b0;
      fwd_data  <= {DW{1'b0}};
      fwd_valid <= 1'b0;
    end
    else if (ce)
    begin
      pkt_ready <= f_in_ready;
      if (!fwd_valid || fwd_ready)
      begin
        fwd_valid <= f_valid;
        fwd_data  <= f_data;
      end
    end
  end

  rxpq_fifo #(.WIDTH(DW), .DEPTH(FIFO_D), .AW(3)) u_fifo
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_data   (pkt_data),
    .in_valid  (f_push && pkt_ready),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (!fwd_valid || fwd_ready)
  );

  rxpq_refclk_meter u_meter
  (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .ce               (ce),
    .ref_tick         (ref_tick),
    .ref_freq_measure (freq)
  );
endmodule // rxpq_core

// ===== core/rxpq_defines.vh
`ifndef RXPQ_DEFINES_VH
`define RXPQ_DEFINES_VH
// Register offsets
`define RXPQ_OFS_PORT_SEL     8'h4C
`define RXPQ_OFS_POL_CFG      8'h7C
`define RXPQ_OFS_PASS_CTL     8'h7D
`define RXPQ_OFS_RISE_MASK    8'h7E
`define RXPQ_OFS_FALL_MASK    8'h7F
`define RXPQ_OFS_REF_FREQ     8'hA5
`define RXPQ_OFS_RISE_STS     8'h80
`define RXPQ_OFS_FALL_STS     8'h81
`define RXPQ_OFS_PASS_STS     8'h82
// Field positions, polarity config
`define RXPQ_FV_POL_BIT       0
`define RXPQ_LV_POL_BIT       1
`define RXPQ_TRUNC_PAR_BIT    5
// Field positions, pass control
`define RXPQ_DISCARD_EN_BIT   7
`define RXPQ_LINE_CNT_BIT     5
`define RXPQ_LINE_SIZE_BIT    4
`define RXPQ_PAR_MODE_BIT     3
`define RXPQ_WDOG_OFF_BIT     2
`define RXPQ_THRESH_MSB       1
`define RXPQ_THRESH_LSB       0
// Reset values
`define RXPQ_RST_POL_CFG      8'h20
`define RXPQ_RST_PASS_CTL     8'h00
`define RXPQ_RST_MASK         8'h00
`define RXPQ_RST_PORT_SEL     8'h00
// Timing: reference clock measured over a 1 us gate
`define RXPQ_CLK_MHZ          100
`define RXPQ_GATE_NS          1000
`define RXPQ_GATE_CYC         ((`RXPQ_GATE_NS * `RXPQ_CLK_MHZ) / 1000)
`endif

// ===== core/rxpq_fifo.v
`timescale 1ns/10ps
// ************************************************************
// Packet word FIFO
// ************************************************************
module rxpq_fifo
#(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Storage
  reg [AW:0]      wr_ptr;           // Write pointer
  reg [AW:0]      rd_ptr;           // Read pointer
  wire            full;             // No room
  wire            empty;            // Nothing stored
  wire            pop;              // Move a word to the output register
  wire [AW:0]     used;             // Words held in storage
  assign full     = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty    = (wr_ptr == rd_ptr);
  assign used     = wr_ptr - rd_ptr;
  // Keep one slot spare so a ready registered one cycle late never overfills
  assign in_ready = (used < (DEPTH[AW:0] - {{AW{1'b0}}, 1'b1}));
  assign pop      = !empty && (!out_valid || out_ready);
  // Storage write
  always @(posedge clk)
  begin
    if (ce && in_valid && !full)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  // Pointers and registered output
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr    <= {(AW+1){1'b0}};
      rd_ptr    <= {(AW+1){1'b0}};
      out_data  <= {WIDTH{1'b0}};
      out_valid <= 1'b0;
    end
    else if (ce)
    begin
      if (in_valid && !full)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
      begin
        out_data  <= mem[rd_ptr[AW-1:0]];
        out_valid <= 1'b1;
        rd_ptr    <= rd_ptr + 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end
endmodule // rxpq_fifo

// ===== core/rxpq_refclk_meter.v
`timescale 1ns/10ps
`include "rxpq_defines.vh"
// ************************************************************
// Reference clock frequency meter
// ************************************************************
module rxpq_refclk_meter
#(
  parameter GATE_CYC = `RXPQ_GATE_CYC
)
(
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire       ref_tick,
  output reg  [7:0] ref_freq_measure
);
  reg [15:0] gate_cnt;  // Gate window counter
  reg [7:0]  edge_cnt;  // Reference edges within gate
  // Count edges over 1 us; result is MHz, not synchronised to reads
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gate_cnt         <= 16'h0000;
      edge_cnt         <= 8'h00;
      ref_freq_measure <= 8'h00;
    end
    else if (ce)
    begin
      if (gate_cnt == GATE_CYC[15:0] - 16'h0001)
      begin
        gate_cnt         <= 16'h0000;
        ref_freq_measure <= edge_cnt + {7'h00, ref_tick};
        edge_cnt         <= 8'h00;
      end
      else
      begin
        gate_cnt <= gate_cnt + 16'h0001;
        if (ref_tick && edge_cnt != 8'hFF)
          edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end
endmodule // rxpq_refclk_meter

// ===== sim/rxpq_core_asserts.sv
`timescale 1ns/10ps
// ****************************************
// Port checker for the pass qualifier
// ****************************************
module rxpq_core_asserts(
  input wire       clk,
  input wire       sys_rst,
  input wire       ce,
  input wire [7:0] reg_rdata,
  input wire       reg_rd,
  input wire [1:0] rx_lock,
  input wire [1:0] parity_err,
  input wire [9:0] fwd_data,
  input wire       fwd_valid,
  input wire       fwd_ready,
  input wire [1:0] port_pass,
  input wire [1:0] frame_truncate
);
  // One clock domain, reset disables all
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_par_drop_p0: assert property (ce && parity_err[0] |=> !port_pass[0])
    else $error("port 0 pass kept after parity error");
  chk_par_drop_p1: assert property (ce && parity_err[1] |=> !port_pass[1])
    else $error("port 1 pass kept after parity error");
  chk_pass_lock_p0: assert property ($rose(port_pass[0]) |-> $past(rx_lock[0]))
    else $error("port 0 pass rose without lock");
  chk_pass_lock_p1: assert property ($rose(port_pass[1]) |-> $past(rx_lock[1]))
    else $error("port 1 pass rose without lock");
  chk_trunc_cause: assert property (frame_truncate[0] |->
    $past(parity_err[0]) || $past(parity_err[0], 2))
    else $error("truncation without parity error");
  chk_trunc_single: assert property (frame_truncate[0] |=> !frame_truncate[0])
    else $error("truncation pulse longer than one cycle");
  chk_fwd_hold: assert property (fwd_valid && !fwd_ready |=>
    fwd_valid && $stable(fwd_data))
    else $error("forwarded word changed while stalled");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
endmodule // rxpq_core_asserts

// ===== sim/rxpq_ser_model.sv
`timescale 1ns/10ps
// ****************************************
// Remote serializer sync model
// ****************************************
module rxpq_ser_model(
  input  wire clk,
  input  wire fv_pol,
  input  wire lv_pol,
  output wire raw_fv,
  output wire raw_lv
);
  reg fv_act = 1'b0; // Frame in progress
  reg lv_act = 1'b0; // Line in progress
  // Syncs leave with the programmed polarity
  assign raw_fv = fv_act ^ fv_pol;
  assign raw_lv = lv_act ^ lv_pol;
  // One frame of nl lines of ll cycles each
  task send_frame(input integer nl, input integer ll);
    integer k;
    begin
      @(posedge clk);
      #1 fv_act = 1'b1;
      repeat (2) @(posedge clk);
      for (k = 0; k < nl; k = k + 1)
      begin
        #1 lv_act = 1'b1;
        repeat (ll) @(posedge clk);
        #1 lv_act = 1'b0;
        repeat (2) @(posedge clk);
      end
      #1 fv_act = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
endmodule // rxpq_ser_model

// ===== sim/rxpq_tb.sv
`timescale 1ns/10ps
`include "rxpq_defines.vh"
// ****************************************
// Self-checking bench
// ****************************************
module testbench;
  reg         clk = 1'b0;      // Core clock
  reg         sys_rst = 1'b1;  // Async reset
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  wire [7:0]  reg_rdata;
  reg  [1:0]  rx_lock = 2'h0;
  reg  [1:0]  parity_err = 2'h0;
  reg  [15:0] sens = 16'h0000;   // Remote sensor status
  reg         ref_tick = 1'b0;
  reg  [9:0]  pkt_data = 10'h000;
  reg         pkt_valid = 1'b0;
  wire        pkt_ready;
  wire [9:0]  fwd_data;
  wire        fwd_valid;
  reg         fwd_ready = 1'b0;
  wire [1:0]  port_pass;
  wire [1:0]  trunc;             // Frame truncation pulses
  wire        fv_w;
  wire        lv_w;
  reg         fv_pol = 1'b0;
  reg         lv_pol = 1'b0;
  reg  [7:0]  d;
  reg  [7:0]  e;
  reg  [7:0]  v;
  reg  [9:0]  w;
  reg  [9:0]  exq[$];            // Words expected out
  reg  [9:0]  got[$];            // Words seen out
  integer     miscompares = 0;
  integer     tests_run = 0;
  integer     tk = 0;
  integer     i;
  integer     n;

  rxpq_core #(.WD_LIMIT(24'd200)) DUT (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_lock(rx_lock), .raw_fv({fv_w, fv_w}),
    .raw_lv({lv_w, lv_w}), .parity_err(parity_err), .remote_sensor_status(sens),
    .ref_tick(ref_tick), .pkt_port(2'h0), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .fwd_data(fwd_data), .fwd_valid(fwd_valid),
    .fwd_ready(fwd_ready), .port_pass(port_pass), .frame_truncate(trunc));
  rxpq_ser_model SER (.clk(clk), .fv_pol(fv_pol), .lv_pol(lv_pol), .raw_fv(fv_w),
    .raw_lv(lv_w));

  // Clock, reset and reference ticks every 4 cycles
  always #5 clk = ~clk;
  initial
  begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
  end
  always @(posedge clk)
  begin
    #1 tk = tk + 1;
    ref_tick = (tk % 4 == 0);
  end
  // Collect forwarded words
  always @(posedge clk)
    if (fwd_valid && fwd_ready)
      got.push_back(fwd_data);

  // Expected latched edges and frequency
  function [7:0] edge_hits(input [7:0] mask, input [7:0] sv);
    edge_hits = mask & sv;
  endfunction
  function [7:0] ref_mhz(input integer div);
    ref_mhz = `RXPQ_GATE_CYC / div;
  endfunction

  task chk_val(input [9:0] gv, input [9:0] ev);
    begin
      tests_run = tests_run + 1;
      if (gv !== ev)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gv, ev);
      end
    end
  endtask
  task chk_bit(input gb, input eb);
    chk_val({9'h000, gb}, {9'h000, eb});
  endtask
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] dv);
    begin
      reg_addr = a;
      reg_wdata = dv;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      step(1);
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] ev);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      step(1);
      chk_val({2'h0, reg_rdata}, {2'h0, ev});
    end
  endtask
  // Offer one word until it is taken
  task push(input [9:0] pv);
    begin
      pkt_data = pv;
      pkt_valid = 1'b1;
      while (!pkt_ready)
        step(1);
      step(1);
    end
  endtask
  task done(input string nm);
    $display("test %s done", nm);
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // Hang guard
  initial
  begin
    #300000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(64));
    v = 8'($urandom);
    @(negedge sys_rst);
    step(1);
    rdchk(8'h7C, `RXPQ_RST_POL_CFG);
    rdchk(8'h7D, 8'h00);
    rdchk(8'h7E, 8'h00);
    rdchk(8'h7F, 8'h00);
    rdchk(8'hA0, 8'h00);
    {lv_pol, fv_pol} = v[1:0];
    wr(8'h4C, 8'h03);
    wr(8'h7C, {6'h08, lv_pol, fv_pol});
    wr(8'h4C, 8'h02);
    rdchk(8'h7C, {6'h08, lv_pol, fv_pol});
    done("registers");
    // Threshold zero follows lock, parity drops one port
    rx_lock = 2'b01;
    step(2);
    chk_val({8'h00, port_pass}, 10'h001);
    rx_lock = 2'b11;
    step(2);
    for (i = 1; i < 3; i = i + 1)
    begin
      parity_err = i[1:0];
      step(1);
      parity_err = 2'b00;
      chk_val({8'h00, port_pass}, {8'h00, 2'b11 ^ i[1:0]});
      step(1);
      chk_val({8'h00, port_pass}, 10'h003);
    end
    done("lock");
    // Frame counting and qualification checks on port 0
    wr(8'h4C, 8'h01);
    wr(8'h7D, 8'h02);
    rx_lock = 2'b10;
    step(2);
    rx_lock = 2'b11;
    step(2);
    chk_bit(port_pass[0], 1'b0);
    SER.send_frame(3, 6);
    chk_bit(port_pass[0], 1'b0);
    SER.send_frame(3, 6);
    chk_bit(port_pass[0], 1'b1);
    wr(8'h7D, 8'h22);
    SER.send_frame(4, 6);
    chk_bit(port_pass[0], 1'b0);
    SER.send_frame(4, 6);
    SER.send_frame(4, 6);
    chk_bit(port_pass[0], 1'b1);
    wr(8'h7D, 8'h12);
    SER.send_frame(4, 8);
    chk_bit(port_pass[0], 1'b0);
    SER.send_frame(4, 8);
    SER.send_frame(4, 8);
    chk_bit(port_pass[0], 1'b1);
    wr(8'h7D, 8'h0A);
    fork
      SER.send_frame(4, 8);
      begin
        step(6);
        parity_err = 2'b01;
        step(1);
        parity_err = 2'b00;
        chk_bit(trunc[0], 1'b1);
      end
    join
    chk_bit(port_pass[0], 1'b0);
    SER.send_frame(4, 8);
    chk_bit(port_pass[0], 1'b0);
    SER.send_frame(4, 8);
    chk_bit(port_pass[0], 1'b1);
    done("frames");
    // Frame-end watchdog
    step(450);
    chk_bit(port_pass[0], 1'b0);
    wr(8'h7D, 8'h05);
    SER.send_frame(3, 6);
    chk_bit(port_pass[0], 1'b1);
    rdchk(8'h82, 8'h01);
    step(450);
    chk_bit(port_pass[0], 1'b1);
    wr(8'h7D, 8'h00);
    step(450);
    chk_bit(port_pass[0], 1'b1);
    done("watchdog");
    // Sensor status edge latches
    d = 8'($urandom);
    e = 8'($urandom);
    v = 8'($urandom);
    wr(8'h7E, d);
    wr(8'h7F, e);
    sens = {8'h00, v};
    step(2);
    sens = 16'h0000;
    step(2);
    rdchk(8'h80, edge_hits(d, v));
    rdchk(8'h81, edge_hits(e, v));
    rdchk(8'h80, 8'h00);
    wr(8'h4C, 8'h02);
    rdchk(8'h7E, 8'h00);
    wr(8'h4C, 8'h01);
    done("sensor");
    // Discard while pass is false, then fill and drain the FIFO
    rx_lock = 2'b00;
    wr(8'h7D, 8'h80);
    fwd_ready = 1'b1;
    push(10'h155);
    pkt_valid = 1'b0;
    step(10);
    chk_bit(got.size() == 0, 1'b1);
    wr(8'h7D, 8'h00);
    fwd_ready = 1'b0;
    n = 0;
    for (i = 0; i < 16 && pkt_ready; i = i + 1)
    begin
      w = 10'($urandom);
      exq.push_back(w);
      push(w);
      n = n + 1;
    end
    pkt_valid = 1'b0;
    chk_bit(n >= 8, 1'b1);
    for (i = 0; i < 300 && got.size() < n; i = i + 1)
    begin
      fwd_ready = 1'($urandom);
      step(1);
    end
    fwd_ready = 1'b1;
    step(4);
    chk_bit(got.size() == n, 1'b1);
    for (i = 0; i < n && i < got.size(); i = i + 1)
      chk_val(got[i], exq[i]);
    chk_bit(fwd_valid, 1'b0);
    done("packets");
    // Reference frequency, read twice until stable
    wr(8'hA5, 8'hFF);
    for (i = 0; i < 4 && (i == 0 || d !== e); i = i + 1)
    begin
      rdchk(8'hA5, ref_mhz(4));
      d = reg_rdata;
      rdchk(8'hA5, ref_mhz(4));
      e = reg_rdata;
    end
    chk_bit(d === e, 1'b1);
    done("refclk");
    tally_and_finish;
  end
endmodule // testbench

bind rxpq_core rxpq_core_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
  .reg_rdata(reg_rdata), .reg_rd(reg_rd), .rx_lock(rx_lock), .parity_err(parity_err),
  .fwd_data(fwd_data), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
  .port_pass(port_pass), .frame_truncate(frame_truncate));
